// *** rtl/mul_neg_pkg.sv ***
/*
 * Constants shared by the multiply/negate execution datapath: opcode
 * patterns, instruction field positions, status bit positions, register
 * port offsets and reset values.
 * Assumes a byte-wide core with a 4096-byte data space.
 */
package mul_neg_pkg;

    // Instruction fields
    localparam int unsigned LIT_LSB = 0;
    localparam int unsigned LIT_W = 8;
    localparam int unsigned ACC_BIT = 8;
    localparam int unsigned OPHI_LSB = 9;

    // Opcode patterns
    localparam logic [7:0] MUL_LIT_OPC = 8'h0d;        // upper byte of multiply_literal_op
    localparam logic [6:0] MUL_FILE_OPC = 7'h01;       // bits 15:9 of multiply_file_op
    localparam logic [6:0] NEG_FILE_OPC = 7'h36;       // bits 15:9 of negate_file_op
    localparam logic [15:0] IDLE_ZERO_OPC = 16'h0000;  // idle_op, all zeros
    localparam logic [3:0] IDLE_TOP_OPC = 4'hf;        // idle_op, leading nibble

    // Addressing
    localparam logic [7:0] ACCESS_LIMIT = 8'h5f;       // last low access-bank address
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

    // Status bit positions
    localparam int unsigned ST_C = 0;
    localparam int unsigned ST_DC = 1;
    localparam int unsigned ST_Z = 2;
    localparam int unsigned ST_OV = 3;
    localparam int unsigned ST_N = 4;
    localparam int unsigned ST_W = 5;

    // Register port offsets
    localparam logic [3:0] ACCUM_OFS = 4'h0;
    localparam logic [3:0] BANK_SEL_OFS = 4'h1;
    localparam logic [3:0] PROD_LOW_OFS = 4'h2;
    localparam logic [3:0] PROD_HIGH_OFS = 4'h3;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] CONFIG_OFS = 4'h5;
    localparam logic [3:0] INDEX_LOW_OFS = 4'h6;
    localparam logic [3:0] INDEX_HIGH_OFS = 4'h7;
    localparam logic [3:0] PTR_LOW_OFS = 4'h8;
    localparam logic [3:0] PTR_HIGH_OFS = 4'h9;
    localparam logic [3:0] MEM_DATA_OFS = 4'ha;

    // Config fields
    localparam int unsigned CFG_EXT_BIT = 0;

    // Reset values
    localparam logic [7:0] ACCUM_RST = 8'h00;
    localparam logic [3:0] BANK_SEL_RST = 4'h0;
    localparam logic [7:0] PROD_RST = 8'h00;
    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic EXT_RST = 1'b0;
    localparam logic [11:0] INDEX_RST = 12'h000;
    localparam logic [11:0] PTR_RST = 12'h000;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic DONE_RST = 1'b0;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_MUL_LIT,
        OP_MUL_FILE,
        OP_NEG_FILE,
        OP_IDLE
    } op_e;

endpackage : mul_neg_pkg

// *** rtl/file_store.sv ***
/*
 * Byte-wide data space held in flip-flops: two combinational read ports
 * and one write port that lands at the clock edge.
 * Assumes the owner resolves write conflicts before the port.
 */
`timescale 1ns/10ps
`default_nettype none

module file_store #(
    parameter int unsigned ADDR_W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Write port
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read ports
    input wire logic [ADDR_W-1:0] rd_addr_a,
    output logic [7:0] rd_data_a,
    input wire logic [ADDR_W-1:0] rd_addr_b,
    output logic [7:0] rd_data_b
);

    localparam int unsigned DEPTH = 1 << ADDR_W;

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } store_s;

    store_s st_q;
    store_s st_d;

    always_comb begin
        st_d = st_q;
        if (ce && wr_en) begin
            st_d.mem[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data_a = st_q.mem[rd_addr_a];
    assign rd_data_b = st_q.mem[rd_addr_b];

endmodule : file_store

`default_nettype wire

// *** rtl/multiply_negate_exec.sv ***
/*
 * Execution datapath for the multiply, negate and idle instructions of an
 * 8-bit core, with the accumulator, bank select, product pair, status,
 * index pointer and a byte data space reachable over a plain register port.
 * Assumes one instruction word per cycle, presented with instr_valid on the
 * same clock, and a register master that never strobes read and write at once.
 */
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - The multiply-literal opcode writes accumulator times the low literal byte to the product pair, accumulator kept.
// - The multiply-file opcode writes accumulator times the addressed file byte to the product pair, neither operand changed.
// - The upper product byte goes to product_high and the lower byte to product_low.
// - Neither multiply touches any status flag, and a zero product sets no zero flag.
// - For file forms, access bit 0 targets the access bank and access bit 1 takes the bank from bank_select_register.
// - With the extended set on, access bit 0 and address up to 95, file forms use index pointer plus literal offset.
// - The negate-file opcode writes the two's complement back to the file byte and updates N, OV, C, DC and Z.
module multiply_negate_exec #(
    parameter int unsigned ADDR_W = 12
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Instruction stream
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    output logic instr_done,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Visible state
    output logic [7:0] product_high,
    output logic [7:0] product_low,
    output logic [4:0] status_flags
);

    typedef struct packed {
        logic [7:0] accum;
        logic [3:0] bank_sel;
        logic [7:0] prod_low;
        logic [7:0] prod_high;
        logic [mul_neg_pkg::ST_W-1:0] status;
        logic ext_en;
        logic [11:0] index_ptr;
        logic [11:0] mem_ptr;
        logic [7:0] rdata;
        logic done;
    } state_s;

    state_s st_q;
    state_s st_d;

    logic [ADDR_W-1:0] op_addr;
    logic [7:0] op_data;
    logic [7:0] sw_data;
    logic ram_wr;
    logic [ADDR_W-1:0] ram_wr_addr;
    logic [7:0] ram_wr_data;

    // Classify one instruction word
    function automatic mul_neg_pkg::op_e decode_op(input logic [15:0] w);
        mul_neg_pkg::op_e op;
        op = mul_neg_pkg::OP_NONE;
        if (w[15:8] == mul_neg_pkg::MUL_LIT_OPC) begin
            op = mul_neg_pkg::OP_MUL_LIT;
        end else if (w[15:mul_neg_pkg::OPHI_LSB] == mul_neg_pkg::MUL_FILE_OPC) begin
            op = mul_neg_pkg::OP_MUL_FILE;
        end else if (w[15:mul_neg_pkg::OPHI_LSB] == mul_neg_pkg::NEG_FILE_OPC) begin
            op = mul_neg_pkg::OP_NEG_FILE;
        end else if (w == mul_neg_pkg::IDLE_ZERO_OPC || w[15:12] == mul_neg_pkg::IDLE_TOP_OPC) begin
            op = mul_neg_pkg::OP_IDLE;
        end
        return op;
    endfunction : decode_op

    // Resolve the file operand address from access bit and literal address
    function automatic logic [11:0] file_addr(
        input logic acc,
        input logic [7:0] f,
        input logic ext,
        input logic [3:0] bank,
        input logic [11:0] index
    );
        logic [11:0] a;
        a = {bank, f};
        if (!acc) begin
            if (ext && f <= mul_neg_pkg::ACCESS_LIMIT) begin
                a = index + {4'h0, f};
            end else if (f <= mul_neg_pkg::ACCESS_LIMIT) begin
                a = {mul_neg_pkg::ACCESS_LOW_BANK, f};
            end else begin
                a = {mul_neg_pkg::ACCESS_HIGH_BANK, f};
            end
        end
        return a;
    endfunction : file_addr

    // Both factors widen before the multiply, so the high product byte is never cut off
    function automatic logic [15:0] mul_bytes(input logic [7:0] x, input logic [7:0] y);
        logic [15:0] wide_x;
        logic [15:0] wide_y;
        wide_x = {8'h00, x};
        wide_y = {8'h00, y};
        return wide_x * wide_y;
    endfunction : mul_bytes

    // Negate flags come from the adder that forms ~f + 1, so they match an ordinary add
    function automatic logic [mul_neg_pkg::ST_W-1:0] neg_status(
        input logic [mul_neg_pkg::ST_W-1:0] old,
        input logic [7:0] f
    );
        logic [mul_neg_pkg::ST_W-1:0] s;
        logic [4:0] low_sum;
        logic [8:0] full_sum;
        s = old;
        low_sum = {1'b0, ~f[3:0]} + 5'h01;
        full_sum = {1'b0, ~f} + 9'h001;
        s[mul_neg_pkg::ST_C] = full_sum[8];
        s[mul_neg_pkg::ST_DC] = low_sum[4];
        s[mul_neg_pkg::ST_Z] = (full_sum[7:0] == 8'h00);
        // Adding one to a non-negative addend overflows only into the sign bit
        s[mul_neg_pkg::ST_OV] = f[7] && full_sum[7];
        s[mul_neg_pkg::ST_N] = full_sum[7];
        return s;
    endfunction : neg_status

    // Operand address for the current instruction
    always_comb begin
        logic [11:0] full;
        full = file_addr(instr[mul_neg_pkg::ACC_BIT], instr[7:0], st_q.ext_en,
            st_q.bank_sel, st_q.index_ptr);
        op_addr = full[ADDR_W-1:0];
    end

    file_store #(
        .ADDR_W(ADDR_W)
    ) u_store (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .wr_en(ram_wr),
        .wr_addr(ram_wr_addr),
        .wr_data(ram_wr_data),
        .rd_addr_a(op_addr),
        .rd_data_a(op_data),
        .rd_addr_b(st_q.mem_ptr[ADDR_W-1:0]),
        .rd_data_b(sw_data)
    );

    always_comb begin
        mul_neg_pkg::op_e op;
        logic [15:0] product;
        logic [7:0] neg;
        logic sw_mem_wr;
        op = mul_neg_pkg::OP_NONE;
        product = 16'h0000;
        neg = 8'h00;
        sw_mem_wr = 1'b0;
        st_d = st_q;
        ram_wr = 1'b0;
        ram_wr_addr = op_addr;
        ram_wr_data = 8'h00;
        st_d.done = 1'b0;
        st_d.rdata = 8'h00;

        // Software writes first; a same-cycle instruction result overrides them
        if (reg_wr) begin
            case (reg_addr)
                mul_neg_pkg::ACCUM_OFS: st_d.accum = reg_wdata;
                mul_neg_pkg::BANK_SEL_OFS: st_d.bank_sel = reg_wdata[3:0];
                mul_neg_pkg::PROD_LOW_OFS: st_d.prod_low = reg_wdata;
                mul_neg_pkg::PROD_HIGH_OFS: st_d.prod_high = reg_wdata;
                mul_neg_pkg::STATUS_OFS: st_d.status = reg_wdata[mul_neg_pkg::ST_W-1:0];
                mul_neg_pkg::CONFIG_OFS: st_d.ext_en = reg_wdata[mul_neg_pkg::CFG_EXT_BIT];
                mul_neg_pkg::INDEX_LOW_OFS: st_d.index_ptr[7:0] = reg_wdata;
                mul_neg_pkg::INDEX_HIGH_OFS: st_d.index_ptr[11:8] = reg_wdata[3:0];
                mul_neg_pkg::PTR_LOW_OFS: st_d.mem_ptr[7:0] = reg_wdata;
                mul_neg_pkg::PTR_HIGH_OFS: st_d.mem_ptr[11:8] = reg_wdata[3:0];
                mul_neg_pkg::MEM_DATA_OFS: begin
                    sw_mem_wr = 1'b1;
                    st_d.mem_ptr = st_q.mem_ptr + 12'h001;
                end
                default: ;
            endcase
        end

        // Reads answer in the next cycle; unmapped offsets read zero
        if (reg_rd) begin
            case (reg_addr)
                mul_neg_pkg::ACCUM_OFS: st_d.rdata = st_q.accum;
                mul_neg_pkg::BANK_SEL_OFS: st_d.rdata = {4'h0, st_q.bank_sel};
                mul_neg_pkg::PROD_LOW_OFS: st_d.rdata = st_q.prod_low;
                mul_neg_pkg::PROD_HIGH_OFS: st_d.rdata = st_q.prod_high;
                mul_neg_pkg::STATUS_OFS: st_d.rdata = {3'h0, st_q.status};
                mul_neg_pkg::CONFIG_OFS: st_d.rdata = {7'h00, st_q.ext_en};
                mul_neg_pkg::INDEX_LOW_OFS: st_d.rdata = st_q.index_ptr[7:0];
                mul_neg_pkg::INDEX_HIGH_OFS: st_d.rdata = {4'h0, st_q.index_ptr[11:8]};
                mul_neg_pkg::PTR_LOW_OFS: st_d.rdata = st_q.mem_ptr[7:0];
                mul_neg_pkg::PTR_HIGH_OFS: st_d.rdata = {4'h0, st_q.mem_ptr[11:8]};
                mul_neg_pkg::MEM_DATA_OFS: begin
                    st_d.rdata = sw_data;
                    st_d.mem_ptr = st_q.mem_ptr + 12'h001;
                end
                default: st_d.rdata = 8'h00;
            endcase
        end

        if (sw_mem_wr) begin
            ram_wr = 1'b1;
            ram_wr_addr = st_q.mem_ptr[ADDR_W-1:0];
            ram_wr_data = reg_wdata;
        end

        // One instruction word completes per cycle
        if (instr_valid) begin
            op = decode_op(instr);
            case (op)
                mul_neg_pkg::OP_MUL_LIT: begin
                    product = mul_bytes(st_q.accum,
                        instr[mul_neg_pkg::LIT_LSB +: mul_neg_pkg::LIT_W]);
                    st_d.prod_high = product[15:8];
                    st_d.prod_low = product[7:0];
                    st_d.status = st_q.status;
                    st_d.done = 1'b1;
                end
                mul_neg_pkg::OP_MUL_FILE: begin
                    product = mul_bytes(st_q.accum, op_data);
                    st_d.prod_high = product[15:8];
                    st_d.prod_low = product[7:0];
                    st_d.status = st_q.status;
                    st_d.done = 1'b1;
                end
                mul_neg_pkg::OP_NEG_FILE: begin
                    neg = ~op_data + 8'h01;
                    ram_wr = 1'b1;
                    ram_wr_addr = op_addr;
                    ram_wr_data = neg;
                    st_d.status = neg_status(st_q.status, op_data);
                    // Pointer still advances if a data write was displaced
                    st_d.done = 1'b1;
                end
                mul_neg_pkg::OP_IDLE: begin
                    st_d.done = 1'b1;
                end
                default: ;
            endcase
        end

        // Clock enable low freezes everything, read answer included
        if (!ce) begin
            st_d = st_q;
            ram_wr = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q.accum <= mul_neg_pkg::ACCUM_RST;
            st_q.bank_sel <= mul_neg_pkg::BANK_SEL_RST;
            st_q.prod_low <= mul_neg_pkg::PROD_RST;
            st_q.prod_high <= mul_neg_pkg::PROD_RST;
            st_q.status <= mul_neg_pkg::STATUS_RST;
            st_q.ext_en <= mul_neg_pkg::EXT_RST;
            st_q.index_ptr <= mul_neg_pkg::INDEX_RST;
            st_q.mem_ptr <= mul_neg_pkg::PTR_RST;
            st_q.rdata <= mul_neg_pkg::RDATA_RST;
            st_q.done <= mul_neg_pkg::DONE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign instr_done = st_q.done;
    assign reg_rdata = st_q.rdata;
    assign product_high = st_q.prod_high;
    assign product_low = st_q.prod_low;
    assign status_flags = st_q.status;

endmodule : multiply_negate_exec

`default_nettype wire

// *** tb/multiply_negate_exec_sva.sv ***
/* Port checker for multiply_negate_exec.
   Assumes one clock domain and the opcode layout of mul_neg_pkg. */
`timescale 1ns/10ps
`default_nettype none
module multiply_negate_exec_sva #(
    parameter int unsigned ADDR_W = 12
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Instruction stream
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic instr_done,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Visible state
    input wire logic [7:0] product_high,
    input wire logic [7:0] product_low,
    input wire logic [4:0] status_flags
);
    // Shadow accumulator, since no instruction here may write it
    logic [7:0] acc_q;
    logic lit_go, file_go, neg_go, idle_go, any_go;
    assign lit_go = ce && instr_valid && instr[15:8] == mul_neg_pkg::MUL_LIT_OPC;
    assign file_go = ce && instr_valid && instr[15:9] == mul_neg_pkg::MUL_FILE_OPC;
    assign neg_go = ce && instr_valid && instr[15:9] == mul_neg_pkg::NEG_FILE_OPC;
    assign idle_go = ce && instr_valid && (instr == 16'h0000 || instr[15:12] == 4'hf);
    assign any_go = lit_go || file_go || neg_go || idle_go;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= 8'h00;
        end else if (ce && reg_wr && reg_addr == 4'h0) begin
            acc_q <= reg_wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_mul;
        (lit_go || file_go) && !reg_wr;
    endsequence
    sequence s_neg;
        neg_go;
    endsequence
    a_lit_product: assert property (lit_go |=>
        {product_high, product_low} == $past(acc_q) * $past(instr[7:0]))
        else $error("literal product wrong");
    a_mul_flags: assert property (s_mul |=> $stable(status_flags))
        else $error("multiply changed status");
    a_done_legal: assert property (any_go |=> instr_done)
        else $error("no completion pulse");
    a_done_quiet: assert property (ce && !any_go |=> !instr_done)
        else $error("stray completion pulse");
    a_idle_quiet: assert property (idle_go && !reg_wr |=>
        $stable({product_high, product_low, status_flags})) else $error("idle changed state");
    // Carry and zero agree after negate, and overflow only ever comes with negative
    a_neg_flags: assert property (s_neg |=> status_flags[0] == status_flags[2] &&
        (status_flags[4] || !status_flags[3])) else $error("negate flags inconsistent");
    a_read_idle: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_read_high: assert property (ce && reg_rd && reg_addr == 4'h3 |=>
        reg_rdata == $past(product_high)) else $error("product high read wrong");
    a_read_unmapped: assert property (ce && reg_rd && reg_addr > 4'ha |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_frozen: assert property (!ce |=>
        $stable({product_high, product_low, status_flags, instr_done})) else $error("not frozen");
endmodule : multiply_negate_exec_sva
bind multiply_negate_exec multiply_negate_exec_sva #(.ADDR_W(ADDR_W)) i_sva (
    .clk(clk), .rst_n(rst_n), .ce(ce), .instr_valid(instr_valid), .instr(instr),
    .instr_done(instr_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .product_high(product_high),
    .product_low(product_low), .status_flags(status_flags));
`default_nettype wire

// *** tb/multiply_negate_exec_bench.sv ***
/* Self-checking bench for multiply_negate_exec.
   Assumes the register offsets and opcode layout of mul_neg_pkg. */
`timescale 1ns/10ps
`default_nettype none
module multiply_negate_exec_bench;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, instr_valid = 1'b0, instr_done;
    logic [15:0] instr = 16'h0000;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, product_high, product_low;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0] status_flags;
    logic [31:0] seed = 32'h7f5e;
    int err_count = 0, check_count = 0, cycles = 0;
    always #2.5 clk = ~clk;
    multiply_negate_exec #(.ADDR_W(12)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .instr_valid(instr_valid), .instr(instr), .instr_done(instr_done),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .product_high(product_high), .product_low(product_low),
        .status_flags(status_flags));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Flag order N, OV, Z, DC, C
    function automatic logic [4:0] neg_flags(input logic [7:0] f);
        logic [7:0] r;
        r = ~f + 8'h01;
        return {r[7], f == 8'h80, r == 8'h00, f[3:0] == 4'h0, f == 8'h00};
    endfunction : neg_flags
    function automatic logic [11:0] eff_addr(input logic a, input logic [7:0] f,
        input logic ext, input logic [3:0] bank, input logic [11:0] idx);
        if (a) return {bank, f};
        if (ext && f <= 8'h5f) return idx + {4'h0, f};
        return (f <= 8'h5f) ? {4'h0, f} : {4'hf, f};
    endfunction : eff_addr
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read
    // Pointer is set afresh each time because the data port advances it
    task automatic mem_put(input logic [11:0] a, input logic [7:0] d);
        reg_write(4'h8, a[7:0]);
        reg_write(4'h9, {4'h0, a[11:8]});
        reg_write(4'ha, d);
    endtask : mem_put
    task automatic mem_get(input logic [11:0] a, output logic [7:0] d);
        reg_write(4'h8, a[7:0]);
        reg_write(4'h9, {4'h0, a[11:8]});
        reg_read(4'ha, d);
    endtask : mem_get
    task automatic exec(input logic [15:0] i, input logic done_exp);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= i;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk("instr_done", {15'h0000, done_exp}, {15'h0000, instr_done});
    endtask : exec
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        logic [31:0] r, q;
        logic [15:0] p;
        logic [11:0] ea, idx;
        logic [7:0] f, v, acc, d;
        logic [4:0] st;
        logic [3:0] bank;
        logic a, ext;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            reg_read(k[3:0], d);
            chk("reset read", 16'h0000, {8'h00, d});
        end
        for (int k = 0; k < 24; k++) begin
            r = rnd();
            q = rnd();
            ext = (k >= 12);
            a = r[0];
            f = (k % 4 == 0) ? 8'h5f : (k % 4 == 1) ? 8'h60 : r[15:8];
            v = (k == 2) ? 8'h80 : (k == 3) ? 8'h00 : q[7:0];
            bank = r[19:16];
            idx = r[31:20];
            acc = q[15:8];
            reg_write(4'h5, {7'h00, ext});
            reg_write(4'h1, {4'h0, bank});
            reg_write(4'h6, idx[7:0]);
            reg_write(4'h7, {4'h0, idx[11:8]});
            reg_write(4'h0, acc);
            ea = eff_addr(a, f, ext, bank, idx);
            // Decoy in a neighbouring bank exposes a wrong bank choice
            mem_put(ea ^ 12'h100, ~v);
            mem_put(ea, v);
            st = status_flags;
            exec({7'h01, a, f}, 1'b1);
            chk("file product", 16'(acc) * 16'(v), {product_high, product_low});
            chk("multiply status", {11'h000, st}, {11'h000, status_flags});
            mem_get(ea, d);
            chk("file operand", {8'h00, v}, {8'h00, d});
            reg_read(4'h0, d);
            chk("accumulator", {8'h00, acc}, {8'h00, d});
            exec({7'h36, a, f}, 1'b1);
            chk("negate flags", {11'h000, neg_flags(v)}, {11'h000, status_flags});
            mem_get(ea, d);
            chk("negate result", {8'h00, ~v + 8'h01}, {8'h00, d});
        end
        for (int k = 0; k < 20; k++) begin
            r = rnd();
            acc = (k == 0) ? 8'he2 : r[7:0];
            f = (k == 0) ? 8'hc4 : (k == 1) ? 8'h00 : r[15:8];
            p = 16'(acc) * 16'(f);
            reg_write(4'h0, acc);
            st = status_flags;
            exec({8'h0d, f}, 1'b1);
            chk("literal product", p, {product_high, product_low});
            chk("multiply status", {11'h000, st}, {11'h000, status_flags});
            reg_read(4'h3, d);
            chk("product high read", {8'h00, p[15:8]}, {8'h00, d});
            reg_read(4'h0, d);
            chk("accumulator", {8'h00, acc}, {8'h00, d});
        end
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            p = {product_high, product_low};
            st = status_flags;
            exec((k == 0) ? 16'h0000 : {4'hf, r[11:0]}, 1'b1);
            chk("idle product", p, {product_high, product_low});
            chk("idle status", {11'h000, st}, {11'h000, status_flags});
        end
        exec(16'h0e5a, 1'b0);
        p = {product_high, product_low};
        @(posedge clk);
        ce <= 1'b0;
        exec(16'h0d77, 1'b0);
        chk("frozen product", p, {product_high, product_low});
        @(posedge clk);
        ce <= 1'b1;
        reg_write(4'h5, 8'h00);
        mem_put(12'h020, 8'h3a);
        // Two negates back to back: the second must see the first's result
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= 16'h6c20;
        repeat (2) @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk("second done", 16'h0001, {15'h0000, instr_done});
        chk("double negate flags", {11'h000, neg_flags(8'hc6)}, {11'h000, status_flags});
        mem_get(12'h020, d);
        chk("double negate", 16'h003a, {8'h00, d});
        finish_test();
    end
endmodule : multiply_negate_exec_bench
`default_nettype wire
